// *** dtx_pkg.sv ***
// Contract
// - post-increment pointer write stores register, then bumps pointer; 2 cycles, no flags.
// - pre-decrement pointer write drops pointer first, then stores; 2 cycles, no flags.
// - offset write stores at Y or Z plus displacement; pointer kept; 2 cycles.
// - absolute write stores register at carried address; 2 cycles, no flags.
// - code memory read loads byte at Z into register zero or named; 3 cycles.
// - code memory write stores word of registers one:zero at Z; open-ended, no flags.
// - push writes source register onto stack; 2 cycles, no flags.
// - pop loads destination register from stack; 2 cycles, no flags.
// - sleep takes 1 cycle, no flags, then requests low-power behaviour.
// - watchdog kick takes 1 cycle, no flags, restarts watchdog.
// - break only signals on-chip debug, no flags, 1 cycle.
package dtx_pkg;

  // ----------------------------------------------------------------
  // commands accepted on the command port
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    CMD_NOP       = 5'h00,
    CMD_MW_PTR    = 5'h01,
    CMD_MW_INC    = 5'h02,
    CMD_MW_DEC    = 5'h03,
    CMD_MW_OFS    = 5'h04,
    CMD_MW_ABS    = 5'h05,
    CMD_CR_ZERO   = 5'h06,
    CMD_CR_REG    = 5'h07,
    CMD_CR_INC    = 5'h08,
    CMD_CW        = 5'h09,
    CMD_PUSH      = 5'h0a,
    CMD_POP       = 5'h0b,
    CMD_IO_RD     = 5'h0c,
    CMD_IO_WR     = 5'h0d,
    CMD_SLEEP     = 5'h0e,
    CMD_KICK      = 5'h0f,
    CMD_BREAK     = 5'h10
  } dtx_cmd_t;

  // ----------------------------------------------------------------
  // pointer select codes and register indices
  // ----------------------------------------------------------------
  localparam logic [1:0] PTR_X = 2'h0;
  localparam logic [1:0] PTR_Y = 2'h1;
  localparam logic [1:0] PTR_Z = 2'h2;
  localparam logic [4:0] REG_ZERO = 5'h00;
  localparam logic [4:0] REG_ONE = 5'h01;
  localparam logic [4:0] REG_XL = 5'h1a;
  localparam logic [4:0] REG_YL = 5'h1c;
  localparam logic [4:0] REG_ZL = 5'h1e;

  // ----------------------------------------------------------------
  // cycle counts and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] CYC_MEM = 2'h2;
  localparam logic [1:0] CYC_CODE_RD = 2'h3;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [15:0] SP_RESET = 16'h00ff;
  localparam logic [15:0] ONE_W = 16'h0001;

  // one-hot sequencer states
  typedef enum logic [2:0] {
    SQ_IDLE = 3'b001,
    SQ_BUSY = 3'b010,
    SQ_CW   = 3'b100
  } dtx_state_t;

endpackage : dtx_pkg

// *** dtx_regs.sv ***
`timescale 1ns/100ps
// working register file; pointer pairs live in the top six bytes
module dtx_regs
  import dtx_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic [4:0] rd_addr,
  output logic [7:0] rd_data,
  output logic [15:0] x_val,
  output logic [15:0] y_val,
  output logic [15:0] z_val,
  output logic [15:0] low_register_word,
  input wire logic wr_en,
  input wire logic [4:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic pw_en,
  input wire logic [4:0] pw_addr,
  input wire logic [15:0] pw_val
);
  logic [7:0] rf [32];

  // ----------------------------------------------------------------
  // read side
  // ----------------------------------------------------------------
  assign rd_data = rf[rd_addr];
  assign x_val = {rf[REG_XL + 5'h01], rf[REG_XL]};
  assign y_val = {rf[REG_YL + 5'h01], rf[REG_YL]};
  assign z_val = {rf[REG_ZL + 5'h01], rf[REG_ZL]};
  assign low_register_word = {rf[REG_ONE], rf[REG_ZERO]};

  // ----------------------------------------------------------------
  // write side
  // ----------------------------------------------------------------
  // a byte load overrides a pointer update to the same byte
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      for (int i = 0; i < 32; i++)
      begin
        rf[i] <= 8'h00;
      end
    end
    else
    begin
      if (pw_en)
      begin
        rf[pw_addr] <= pw_val[7:0];
        rf[pw_addr + 5'h01] <= pw_val[15:8];
      end
      if (wr_en)
      begin
        rf[wr_addr] <= wr_data;
      end
    end
  end

endmodule : dtx_regs

// *** dtx_exec.sv ***
`timescale 1ns/100ps
module dtx_exec
  import dtx_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire dtx_pkg::dtx_cmd_t cmd_op,
  input wire logic [4:0] cmd_reg,
  input wire logic [1:0] cmd_ptr,
  input wire logic [5:0] cmd_disp,
  input wire logic [15:0] cmd_addr,
  input wire logic [5:0] cmd_io,
  output logic [15:0] dmem_addr,
  output logic [7:0] dmem_wdata,
  output logic dmem_we,
  output logic dmem_re,
  input wire logic [7:0] dmem_rdata,
  output logic [15:0] pmem_addr,
  output logic pmem_re,
  input wire logic [7:0] pmem_rdata,
  output logic pmem_we,
  output logic [15:0] pmem_wdata,
  input wire logic pmem_wr_done,
  output logic [5:0] io_addr,
  output logic [7:0] io_wdata,
  output logic io_we,
  output logic io_re,
  input wire logic [7:0] io_rdata,
  output logic sleep_req,
  output logic wdt_kick,
  output logic break_hit,
  output logic [15:0] stack_ptr
);
  import dtx_pkg::*;

  dtx_state_t state;
  logic [1:0] busy_left;
  logic accept;
  logic [7:0] rd_data;
  logic [15:0] x_val;
  logic [15:0] y_val;
  logic [15:0] z_val;
  logic [15:0] low_register_word;
  logic [15:0] sel_ptr;
  logic [15:0] ofs_ptr;
  logic [15:0] next_addr;
  logic pw_en;
  logic [4:0] pw_addr;
  logic [15:0] pw_val;
  logic [4:0] pend_dst;
  logic pend_code;
  logic wr_en;
  logic [4:0] wr_addr;
  logic [7:0] wr_data;

  // pick a pointer word by select code
  function automatic logic [15:0] ptr_pick(input logic [1:0] sel, input logic [15:0] x,
                                           input logic [15:0] y, input logic [15:0] z);
    logic [15:0] r;
    r = x;
    if (sel == PTR_Y)
      r = y;
    else if (sel == PTR_Z)
      r = z;
    return r;
  endfunction : ptr_pick

  // index of the low byte of a pointer pair
  function automatic logic [4:0] ptr_base(input logic [1:0] sel);
    logic [4:0] r;
    r = REG_XL;
    if (sel == PTR_Y)
      r = REG_YL;
    else if (sel == PTR_Z)
      r = REG_ZL;
    return r;
  endfunction : ptr_base

  // the command port is only open while idle
  assign accept = cmd_valid && cmd_ready;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  dtx_regs u_regs (
    .mclk(mclk),
    .srst(srst),
    .rd_addr(cmd_reg),
    .rd_data(rd_data),
    .x_val(x_val),
    .y_val(y_val),
    .z_val(z_val),
    .low_register_word(low_register_word),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .pw_en(pw_en),
    .pw_addr(pw_addr),
    .pw_val(pw_val)
  );

  // ----------------------------------------------------------------
  // address generation and pointer side effects
  // ----------------------------------------------------------------
  // offset form only knows Y and Z; any other code falls back to Y
  assign sel_ptr = ptr_pick(cmd_ptr, x_val, y_val, z_val);
  assign ofs_ptr = (cmd_ptr == PTR_Z) ? z_val : y_val;

  always_comb
  begin
    next_addr = sel_ptr;
    pw_en = 1'b0;
    pw_addr = ptr_base(cmd_ptr);
    pw_val = sel_ptr;
    case (cmd_op)
      CMD_MW_INC:
      begin
        pw_en = accept;
        pw_val = sel_ptr + ONE_W;
      end
      CMD_MW_DEC:
      begin
        next_addr = sel_ptr - ONE_W;
        pw_en = accept;
        pw_val = sel_ptr - ONE_W;
      end
      CMD_MW_OFS: next_addr = ofs_ptr + {10'h000, cmd_disp};
      CMD_MW_ABS: next_addr = cmd_addr;
      CMD_PUSH: next_addr = stack_ptr;
      CMD_POP: next_addr = stack_ptr + ONE_W;
      CMD_CR_INC:
      begin
        pw_en = accept;
        pw_addr = REG_ZL;
        pw_val = z_val + ONE_W;
      end
      default: next_addr = sel_ptr;
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer: holds the port closed for the extra cycles
  // ----------------------------------------------------------------
  // nothing here touches status flags; the core keeps them as they were
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      state <= SQ_IDLE;
      busy_left <= 2'h0;
      cmd_ready <= 1'b1;
    end
    else
    begin
      case (state)
        SQ_IDLE:
          if (accept)
          begin
            case (cmd_op)
              CMD_MW_PTR, CMD_MW_INC, CMD_MW_DEC, CMD_MW_OFS, CMD_MW_ABS, CMD_PUSH, CMD_POP:
              begin
                state <= SQ_BUSY;
                busy_left <= CYC_MEM - CYC_ONE;
                cmd_ready <= 1'b0;
              end
              CMD_CR_ZERO, CMD_CR_REG, CMD_CR_INC:
              begin
                state <= SQ_BUSY;
                busy_left <= CYC_CODE_RD - CYC_ONE;
                cmd_ready <= 1'b0;
              end
              CMD_CW:
              begin
                state <= SQ_CW;
                cmd_ready <= 1'b0;
              end
              default: state <= SQ_IDLE;
            endcase
          end
        SQ_BUSY:
        begin
          busy_left <= busy_left - CYC_ONE;
          if (busy_left == CYC_ONE)
          begin
            state <= SQ_IDLE;
            cmd_ready <= 1'b1;
          end
        end
        SQ_CW:
          if (pmem_wr_done)
          begin
            state <= SQ_IDLE;
            cmd_ready <= 1'b1;
          end
        default:
        begin
          state <= SQ_IDLE;
          cmd_ready <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // data space strobes and stack pointer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      dmem_addr <= 16'h0000;
      dmem_wdata <= 8'h00;
      dmem_we <= 1'b0;
      dmem_re <= 1'b0;
      stack_ptr <= SP_RESET;
    end
    else
    begin
      dmem_we <= 1'b0;
      dmem_re <= 1'b0;
      if (accept)
      begin
        dmem_addr <= next_addr;
        dmem_wdata <= rd_data;
        case (cmd_op)
          CMD_MW_PTR, CMD_MW_INC, CMD_MW_DEC, CMD_MW_OFS, CMD_MW_ABS: dmem_we <= 1'b1;
          CMD_PUSH:
          begin
            dmem_we <= 1'b1;
            stack_ptr <= stack_ptr - ONE_W;
          end
          CMD_POP:
          begin
            dmem_re <= 1'b1;
            stack_ptr <= stack_ptr + ONE_W;
          end
          default: dmem_we <= 1'b0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // program memory strobes
  // ----------------------------------------------------------------
  // write strobe stands until the flash reports completion
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      pmem_addr <= 16'h0000;
      pmem_re <= 1'b0;
      pmem_we <= 1'b0;
      pmem_wdata <= 16'h0000;
    end
    else
    begin
      pmem_re <= 1'b0;
      if (pmem_we && pmem_wr_done)
        pmem_we <= 1'b0;
      if (accept && (cmd_op == CMD_CR_ZERO || cmd_op == CMD_CR_REG || cmd_op == CMD_CR_INC))
      begin
        pmem_addr <= z_val;
        pmem_re <= 1'b1;
      end
      if (accept && cmd_op == CMD_CW)
      begin
        pmem_addr <= z_val;
        pmem_wdata <= low_register_word;
        pmem_we <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // i/o port and single-cycle control pulses
  // ----------------------------------------------------------------
  // an i/o read lands in the register one edge later; a command that
  // reads that register right after sees the old value
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      io_addr <= 6'h00;
      io_wdata <= 8'h00;
      io_we <= 1'b0;
      io_re <= 1'b0;
      sleep_req <= 1'b0;
      wdt_kick <= 1'b0;
      break_hit <= 1'b0;
      pend_dst <= REG_ZERO;
      pend_code <= 1'b0;
    end
    else
    begin
      io_we <= accept && cmd_op == CMD_IO_WR;
      io_re <= accept && cmd_op == CMD_IO_RD;
      sleep_req <= accept && cmd_op == CMD_SLEEP;
      wdt_kick <= accept && cmd_op == CMD_KICK;
      break_hit <= accept && cmd_op == CMD_BREAK;
      if (accept)
      begin
        io_addr <= cmd_io;
        io_wdata <= rd_data;
        pend_code <= cmd_op == CMD_CR_ZERO || cmd_op == CMD_CR_REG || cmd_op == CMD_CR_INC;
        pend_dst <= (cmd_op == CMD_CR_ZERO) ? REG_ZERO : cmd_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // register writeback
  // ----------------------------------------------------------------
  always_comb
  begin
    wr_en = 1'b0;
    wr_addr = pend_dst;
    wr_data = io_rdata;
    if (io_re)
      wr_en = 1'b1;
    else if (state == SQ_BUSY && busy_left == CYC_ONE && (dmem_re || pend_code))
    begin
      wr_en = 1'b1;
      wr_data = pend_code ? pmem_rdata : dmem_rdata;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  post_inc_a: assert property (@(posedge mclk) disable iff (srst)
    accept && cmd_op == CMD_MW_INC && cmd_ptr == PTR_Z |=> dmem_we && z_val == dmem_addr + ONE_W
      ##1 cmd_ready)
    else $error("post-increment write wrong");
  pre_dec_a: assert property (@(posedge mclk) disable iff (srst)
    accept && cmd_op == CMD_MW_DEC && cmd_ptr == PTR_X |=> dmem_we && x_val == dmem_addr
      && dmem_addr == $past(x_val) - ONE_W)
    else $error("pre-decrement write wrong");
  offset_wr_a: assert property (@(posedge mclk) disable iff (srst)
    accept && cmd_op == CMD_MW_OFS |=> dmem_we && dmem_addr == $past(ofs_ptr) + {10'h000,
      $past(cmd_disp)} && ofs_ptr == $past(ofs_ptr))
    else $error("offset write wrong");
  abs_wr_a: assert property (@(posedge mclk) disable iff (srst)
    accept && cmd_op == CMD_MW_ABS |=> dmem_we && !cmd_ready && dmem_addr == $past(cmd_addr)
      ##1 cmd_ready && !dmem_we)
    else $error("absolute write wrong");
  code_rd_a: assert property (@(posedge mclk) disable iff (srst)
    accept && cmd_op == CMD_CR_REG |=> pmem_re ##1 !cmd_ready && !pmem_re ##1 cmd_ready)
    else $error("code read timing wrong");
  code_wr_a: assert property (@(posedge mclk) disable iff (srst)
    accept && cmd_op == CMD_CW |=> pmem_we && pmem_wdata == $past(low_register_word)
      && pmem_addr == $past(z_val))
    else $error("code write wrong");
  push_a: assert property (@(posedge mclk) disable iff (srst)
    accept && cmd_op == CMD_PUSH |=> dmem_we && stack_ptr == dmem_addr - ONE_W ##1 cmd_ready)
    else $error("push wrong");
  pop_a: assert property (@(posedge mclk) disable iff (srst)
    accept && cmd_op == CMD_POP |=> dmem_re && stack_ptr == dmem_addr ##1 cmd_ready)
    else $error("pop wrong");
  one_cycle_a: assert property (@(posedge mclk) disable iff (srst)
    accept && (cmd_op == CMD_SLEEP || cmd_op == CMD_KICK || cmd_op == CMD_IO_WR)
      |=> cmd_ready && (sleep_req || wdt_kick || io_we))
    else $error("single cycle command stalled");

endmodule : dtx_exec

// *** dtx_mem_model.sv ***
`timescale 1ns/100ps
// ------------------------------------------------------------
// data space, i/o space and program flash behind the core
// ------------------------------------------------------------
module dtx_mem_model
  import dtx_pkg::*;
(
  input wire logic mclk,
  input wire logic [15:0] dmem_addr,
  input wire logic [7:0] dmem_wdata,
  input wire logic dmem_we,
  input wire logic dmem_re,
  output logic [7:0] dmem_rdata,
  input wire logic [15:0] pmem_addr,
  input wire logic pmem_re,
  output logic [7:0] pmem_rdata,
  input wire logic pmem_we,
  input wire logic [15:0] pmem_wdata,
  output logic pmem_wr_done,
  input wire logic [5:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_we,
  input wire logic io_re,
  output logic [7:0] io_rdata,
  input wire logic [3:0] wr_delay
);
  logic [7:0] dmem [0:65535];
  logic [7:0] pmem [0:65535];
  logic [7:0] io_mem [0:63];
  logic [7:0] junk;
  logic [3:0] wcnt;

  initial
  begin
    junk = 8'h5a;
    wcnt = 4'h0;
    pmem_wr_done = 1'b0;
    pmem_rdata = 8'h00;
  end

  // read data only holds while strobed; a moving pattern otherwise, so stale reads show
  assign dmem_rdata = dmem_re ? dmem[dmem_addr] : junk;
  assign io_rdata = io_re ? io_mem[io_addr] : ~junk;

  // writes land on the edge; flash read data follows one cycle after its strobe
  always @(posedge mclk)
  begin
    junk <= junk + 8'h3b;
    if (dmem_we) dmem[dmem_addr] <= dmem_wdata;
    if (io_we) io_mem[io_addr] <= io_wdata;
    pmem_rdata <= pmem_re ? pmem[pmem_addr] : ~junk;
    pmem_wr_done <= 1'b0;
    // flash write takes wr_delay extra cycles, then one done pulse
    if (pmem_we && !pmem_wr_done)
    begin
      if (wcnt == wr_delay)
      begin
        pmem_wr_done <= 1'b1;
        pmem[pmem_addr] <= pmem_wdata[7:0];
        pmem[pmem_addr + 16'h0001] <= pmem_wdata[15:8];
        wcnt <= 4'h0;
      end
      else
        wcnt <= wcnt + 4'h1;
    end
  end
endmodule : dtx_mem_model

// *** tb_top.sv ***
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end
module tb_top;
  import dtx_pkg::*;
  logic mclk = 1'b0, srst = 1'b1, cmd_valid = 1'b0;
  dtx_cmd_t cmd_op = CMD_NOP;
  logic [4:0] cmd_reg = 5'h00;
  logic [1:0] cmd_ptr = 2'h0;
  logic [5:0] cmd_disp = 6'h00, cmd_io = 6'h00;
  logic [15:0] cmd_addr = 16'h0000, dmem_addr, pmem_addr, pmem_wdata, stack_ptr;
  logic [7:0] dmem_wdata, dmem_rdata, pmem_rdata, io_wdata, io_rdata;
  logic cmd_ready, dmem_we, dmem_re, pmem_re, pmem_we, pmem_wr_done, io_we, io_re;
  logic sleep_req, wdt_kick, break_hit, we_prev = 1'b0;
  logic [5:0] io_addr;
  logic [3:0] wr_delay = 4'h0;
  logic [7:0] regs [0:31];
  logic [7:0] io_copy [0:63];
  logic [15:0] sp = SP_RESET, a;
  logic [35:0] exp_q [$];
  int mismatches = 0, checked = 0, seed = 7108;

  dtx_exec dtx_exec_i (.mclk, .srst, .cmd_valid, .cmd_ready, .cmd_op, .cmd_reg, .cmd_ptr,
    .cmd_disp, .cmd_addr, .cmd_io, .dmem_addr, .dmem_wdata, .dmem_we, .dmem_re, .dmem_rdata,
    .pmem_addr, .pmem_re, .pmem_rdata, .pmem_we, .pmem_wdata, .pmem_wr_done, .io_addr,
    .io_wdata, .io_we, .io_re, .io_rdata, .sleep_req, .wdt_kick, .break_hit, .stack_ptr);
  dtx_mem_model dtx_mem_model_i (.mclk, .dmem_addr, .dmem_wdata, .dmem_we, .dmem_re,
    .dmem_rdata, .pmem_addr, .pmem_re, .pmem_rdata, .pmem_we, .pmem_wdata, .pmem_wr_done,
    .io_addr, .io_wdata, .io_we, .io_re, .io_rdata, .wr_delay);

  // ------------------------------------------------------------
  // clock, watchdog, closing
  // ------------------------------------------------------------
  initial
  begin
    forever #50 mclk = ~mclk;
  end

  initial
  begin
    #(100 * 20000);
    mismatches++;
    end_of_test();
  end

  task end_of_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] ptrv(input int p);
    return {regs[27 + 2 * p], regs[26 + 2 * p]};
  endfunction : ptrv

  task automatic setptr(input int p, input logic [15:0] v);
    {regs[27 + 2 * p], regs[26 + 2 * p]} = v;
  endtask : setptr

  task automatic note(input logic [35:0] e);
    exp_q.push_back(e);
  endtask : note

  // busy below zero means a flash write: at least -busy cycles, bounded above
  task automatic issue(input dtx_cmd_t op, input int r, input int p, input logic [5:0] d,
                       input logic [15:0] ad, input int io, input int busy);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 50)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_reg = 5'(r);
    cmd_ptr = 2'(p);
    cmd_disp = d;
    cmd_addr = ad;
    cmd_io = 6'(io);
    @(posedge mclk);
    #1;
    // a one-cycle command leaves valid standing so the next call never re-raises it
    if (cmd_ready !== 1'b1)
      cmd_valid = 1'b0;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 50)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (busy >= 0)
      `CHK(n, busy)
    else
      `CHK(n >= -busy && n < 20, 1'b1)
  endtask : issue

  // ------------------------------------------------------------
  // monitor: each strobe takes the oldest expected note
  // ------------------------------------------------------------
  task automatic take(input logic [35:0] ev);
    if (exp_q.size() == 0)
      `CHK(ev, 36'h0)
    else
      `CHK(ev, exp_q.pop_front())
  endtask : take

  // sampled mid-cycle, where registered strobes are settled
  always @(negedge mclk)
  begin
    if (dmem_we) take({4'h1, dmem_addr, 8'h00, dmem_wdata});
    if (dmem_re) take({4'h8, dmem_addr, 16'h0000});
    if (io_we) take({4'h2, 10'h000, io_addr, 8'h00, io_wdata});
    if (io_re) take({4'h9, 10'h000, io_addr, 16'h0000});
    if (pmem_re) take({4'h3, pmem_addr, 16'h0000});
    if (pmem_we && !we_prev) take({4'h4, pmem_addr, pmem_wdata});
    if (sleep_req) take({4'h5, 32'h0});
    if (wdt_kick) take({4'h6, 32'h0});
    if (break_hit) take({4'h7, 32'h0});
    we_prev = pmem_we;
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial
  begin
    int r;
    logic [7:0] v;
    for (int i = 0; i < 64; i++)
    begin
      io_copy[i] = 8'($random(seed));
      dtx_mem_model_i.io_mem[i] = io_copy[i];
    end
    repeat (5) @(posedge mclk);
    #1;
    srst = 1'b0;
    `CHK(cmd_ready, 1'b1)
    `CHK(stack_ptr, SP_RESET)
    // every register loaded from its i/o port
    for (int i = 0; i < 32; i++)
    begin
      regs[i] = io_copy[i];
      note({4'h9, 10'h000, 6'(i), 16'h0000});
      issue(CMD_IO_RD, i, 0, 6'h00, 16'h0000, i, 0);
    end
    // plain, post-increment, check, pre-decrement on each pointer
    for (int p = 0; p < 3; p++)
    begin
      r = 2 + ({$random(seed)} % 24);
      a = ptrv(p);
      note({4'h1, a, 8'h00, regs[r]});
      issue(CMD_MW_PTR, r, p, 6'h00, 16'h0000, 0, 1);
      note({4'h1, a, 8'h00, regs[r]});
      issue(CMD_MW_INC, r, p, 6'h00, 16'h0000, 0, 1);
      setptr(p, a + 16'h0001);
      note({4'h1, a + 16'h0001, 8'h00, regs[r]});
      issue(CMD_MW_PTR, r, p, 6'h00, 16'h0000, 0, 1);
      note({4'h1, a, 8'h00, regs[r]});
      issue(CMD_MW_DEC, r, p, 6'h00, 16'h0000, 0, 1);
      setptr(p, a);
    end
    // offset form, widest displacement on the first; X selects Y
    for (int p = 0; p < 3; p++)
    begin
      cmd_disp = (p == 0) ? 6'h3f : 6'($random(seed));
      note({4'h1, ptrv(p == 2 ? 2 : 1) + 16'(cmd_disp), 8'h00, regs[5]});
      issue(CMD_MW_OFS, 5, p, cmd_disp, 16'h0000, 0, 1);
    end
    repeat (3)
    begin
      a = 16'($random(seed));
      note({4'h1, a, 8'h00, regs[7]});
      issue(CMD_MW_ABS, 7, 0, 6'h00, a, 0, 1);
    end
    // push three, pop three, write them back out through i/o ports 40 to 42
    for (int i = 0; i < 3; i++)
    begin
      note({4'h1, sp, 8'h00, regs[3 + i]});
      issue(CMD_PUSH, 3 + i, 0, 6'h00, 16'h0000, 0, 1);
      sp = sp - 16'h0001;
    end
    for (int i = 0; i < 3; i++)
    begin
      sp = sp + 16'h0001;
      regs[10 + i] = regs[5 - i];
      note({4'h8, sp, 16'h0000});
      issue(CMD_POP, 10 + i, 0, 6'h00, 16'h0000, 0, 1);
      note({4'h2, 10'h000, 6'(40 + i), 8'h00, regs[10 + i]});
      issue(CMD_IO_WR, 10 + i, 0, 6'h00, 16'h0000, 40 + i, 0);
    end
    `CHK(stack_ptr, SP_RESET)
    // code reads: implied register zero, named register, post-increment
    for (int f = 0; f < 3; f++)
    begin
      a = ptrv(2);
      v = 8'($random(seed));
      dtx_mem_model_i.pmem[a] = v;
      r = (f == 0) ? 0 : 14 + f;
      regs[r] = v;
      note({4'h3, a, 16'h0000});
      // the implied form is given a foreign register index, which it must ignore
      issue(f == 0 ? CMD_CR_ZERO : f == 1 ? CMD_CR_REG : CMD_CR_INC, f == 0 ? 9 : r, 2, 6'h00,
            16'h0000, 0, 2);
      if (f == 2) setptr(2, a + 16'h0001);
      note({4'h2, 10'h000, 6'h30, 8'h00, v});
      issue(CMD_IO_WR, r, 0, 6'h00, 16'h0000, 48, 0);
    end
    note({4'h1, ptrv(2), 8'h00, regs[2]});
    issue(CMD_MW_PTR, 2, 2, 6'h00, 16'h0000, 0, 1);
    // code write against a prompt and a slow flash
    for (int dl = 0; dl < 7; dl += 6)
    begin
      wr_delay = 4'(dl);
      note({4'h4, ptrv(2), regs[1], regs[0]});
      issue(CMD_CW, 0, 2, 6'h00, 16'h0000, 0, -(dl + 1));
    end
    note({4'h5, 32'h0});
    issue(CMD_SLEEP, 0, 0, 6'h00, 16'h0000, 0, 0);
    note({4'h6, 32'h0});
    issue(CMD_KICK, 0, 0, 6'h00, 16'h0000, 0, 0);
    note({4'h7, 32'h0});
    issue(CMD_BREAK, 0, 0, 6'h00, 16'h0000, 0, 0);
    issue(CMD_NOP, 0, 0, 6'h00, 16'h0000, 0, 0);
    repeat (4) @(posedge mclk);
    `CHK(exp_q.size(), 0)
    end_of_test();
  end
endmodule : tb_top
